// ---- pkg/flash_selfprog_pkg.sv ----
// constants for the program flash self-write controller
package flash_selfprog_pkg;

  // register offsets on the special-function register port
  localparam logic [15:0] OFF_CONTROL   = 16'h0760;
  localparam logic [15:0] OFF_ADDR_LOW  = 16'h0762;
  localparam logic [15:0] OFF_ADDR_HIGH = 16'h0764;
  localparam logic [15:0] OFF_UNLOCK    = 16'h0766;

  // flash_control field positions
  localparam int CTL_START_BIT  = 15;
  localparam int CTL_MODIFY_BIT = 14;
  localparam int CTL_ABORT_BIT  = 13;
  localparam int CTL_OP_LSB     = 0;
  localparam int CTL_OP_W       = 7;

  // operation codes and reset values
  localparam logic [6:0]  OP_ROW_ERASE   = 7'h41;
  localparam logic [6:0]  OP_ROW_PROGRAM = 7'h01;
  localparam logic [6:0]  OP_RESET       = 7'h00;
  localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
  localparam logic [7:0]  ADDR_HIGH_RESET = 8'h00;

  // unlock key sequence
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // flash geometry: 24-bit words, 32 per row, 128 rows per panel
  localparam int WORD_W        = 24;
  localparam int ROW_WORDS     = 32;
  localparam int ROW_IDX_W     = 5;
  localparam int ROW_LSB       = 6;
  localparam int PANEL_ROWS    = 128;
  localparam int LANES         = 3;
  localparam int ADDR_W        = 24;

  // operation time
  localparam longint OP_TIME_NS   = 2000000;
  localparam longint CLK_PERIOD_NS = 4;
  localparam int     OP_CYCLES     = int'(OP_TIME_NS / CLK_PERIOD_NS);
  localparam int     TMR_W         = 19;

endpackage

// ---- src/flash_write_latch_ram.sv ----
// write latches of one panel: 32 program words with byte-lane writes
`timescale 1ns/1ns
`default_nettype none

module flash_write_latch_ram (
  input  wire logic                                      ref_clk_i,
  input  wire logic                                      arst_n_i,
  input  wire logic                                      ce_i,
  input  wire logic                                      we_i,
  input  wire logic [flash_selfprog_pkg::LANES-1:0]      be_i,
  input  wire logic [flash_selfprog_pkg::ROW_IDX_W-1:0]  waddr_i,
  input  wire logic [flash_selfprog_pkg::WORD_W-1:0]     wdata_i,
  input  wire logic                                      re_i,
  input  wire logic [flash_selfprog_pkg::ROW_IDX_W-1:0]  raddr_i,
  output logic      [flash_selfprog_pkg::WORD_W-1:0]     rdata_o
);

  wire [flash_selfprog_pkg::WORD_W-1:0] rd_word;

  // one byte lane per generate step, each with storage of its own so no array has two writers
  for (genvar g = 0; g < flash_selfprog_pkg::LANES; g++) begin : g_lane
    logic [7:0] mem_r [flash_selfprog_pkg::ROW_WORDS];
    always_ff @(posedge ref_clk_i) begin
      if (ce_i && we_i && be_i[g]) begin
        mem_r[waddr_i] <= wdata_i[g*8 +: 8];
      end
    end
    assign rd_word[g*8 +: 8] = mem_r[raddr_i];
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else if (ce_i && re_i) begin
      rdata_o <= rd_word;
    end
  end

endmodule

`default_nettype wire

// ---- src/program_flash_self_write_ctrl.sv ----
// program flash self-write controller: table access, unlock, erase and program
`timescale 1ns/1ns
`default_nettype none

module program_flash_self_write_ctrl #(
  parameter int OP_CYCLES = flash_selfprog_pkg::OP_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  input  wire logic        ext_reset_i,
  input  wire logic        watchdog_reset_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic        tbl_req_i,
  input  wire logic        tbl_write_i,
  input  wire logic        tbl_high_i,
  input  wire logic        tbl_byte_i,
  input  wire logic [15:0] tbl_eff_addr_i,
  input  wire logic [15:0] tbl_wdata_i,
  input  wire logic [7:0]  table_page_i,
  output logic             tbl_done_o,
  output logic      [15:0] tbl_rdata_o,
  output logic             flash_rd_en_o,
  output logic      [23:0] flash_addr_o,
  input  wire logic [23:0] flash_rd_data_i,
  output logic             flash_erase_o,
  output logic             flash_pgm_we_o,
  output logic      [23:0] flash_pgm_data_o,
  output logic             cpu_stall_o,
  output logic             done_flag_o,
  input  wire logic        done_clr_i
);

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_st_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_WAIT} seq_st_t;

  localparam int TW = flash_selfprog_pkg::TMR_W;
  localparam int IW = flash_selfprog_pkg::ROW_IDX_W;
  localparam int RL = flash_selfprog_pkg::ROW_LSB;
  localparam logic [TW-1:0] TMR_LAST = TW'(OP_CYCLES - 1);
  localparam logic [IW-1:0] IDX_LAST = IW'(flash_selfprog_pkg::ROW_WORDS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state
  key_st_t       key_st_r;
  key_st_t       key_st_nxt;
  seq_st_t       seq_r;
  seq_st_t       seq_nxt;
  logic          start_r;
  logic          modify_r;
  logic          abort_flag_r;
  logic [6:0]    op_r;
  logic [15:0]   adr_lo_r;
  logic [7:0]    adr_hi_r;
  logic [TW-1:0] tmr_r;
  logic [IW-1:0] idx_r;
  logic          p1_r;
  logic          th_r;
  logic          tb_r;
  logic          tw_r;
  logic          odd_r;
  logic          rst_meta_r;
  logic          rst_sync_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire idle      = (seq_r == SEQ_IDLE);
  wire wr_con    = reg_wr_i && idle && (reg_addr_i == flash_selfprog_pkg::OFF_CONTROL);
  wire wr_adr_lo = reg_wr_i && idle && (reg_addr_i == flash_selfprog_pkg::OFF_ADDR_LOW);
  wire wr_adr_hi = reg_wr_i && idle && (reg_addr_i == flash_selfprog_pkg::OFF_ADDR_HIGH);
  wire wr_key    = reg_wr_i && idle && (reg_addr_i == flash_selfprog_pkg::OFF_UNLOCK);
  wire abort     = rst_sync_r || watchdog_reset_i;
  wire abort_op  = abort && !idle;

  wire [6:0] new_op    = reg_wdata_i[flash_selfprog_pkg::CTL_OP_LSB +: flash_selfprog_pkg::CTL_OP_W];
  wire       new_mod   = reg_wdata_i[flash_selfprog_pkg::CTL_MODIFY_BIT];
  wire       new_start = reg_wdata_i[flash_selfprog_pkg::CTL_START_BIT];
  wire       is_erase  = (new_op == flash_selfprog_pkg::OP_ROW_ERASE);
  wire       is_prog   = (new_op == flash_selfprog_pkg::OP_ROW_PROGRAM);
  // start needs armed key, modify enable and a known operation
  wire start_ok = wr_con && new_start && new_mod && (is_erase || is_prog)
                  && (key_st_r == KEY_ARMED) && !abort;
  wire op_fin   = (seq_r == SEQ_WAIT) && (tmr_r == TMR_LAST);

  // table access: one in flight, none while an operation runs
  wire take     = ce_i && tbl_req_i && !p1_r && idle;
  wire [23:0] tbl_full_addr = {table_page_i, tbl_eff_addr_i};

  // row select from captured address
  wire [23:0] row_base = {adr_hi_r, adr_lo_r[15:RL], {RL{1'b0}}};
  wire [23:0] pgm_addr = {adr_hi_r, adr_lo_r[15:RL], idx_r, 1'b0};

  // latch write: byte lanes chosen by part, size and odd address
  wire          odd_byte = tbl_byte_i && tbl_eff_addr_i[0];
  wire [2:0]    lat_be   = tbl_high_i ? {!odd_byte, 2'b00}
                                      : {1'b0, !tbl_byte_i || odd_byte,
                                         !tbl_byte_i || !odd_byte};
  wire [23:0]   lat_wd   = {tbl_wdata_i[7:0],
                            odd_byte ? tbl_wdata_i[7:0] : tbl_wdata_i[15:8],
                            tbl_wdata_i[7:0]};
  wire          lat_we   = take && tbl_write_i;
  wire [IW-1:0] lat_widx = tbl_eff_addr_i[IW:1];
  wire          lat_re   = (seq_r == SEQ_LOAD);

  // read data formatting for table reads
  wire [7:0]  lo_byte  = odd_r ? flash_rd_data_i[15:8] : flash_rd_data_i[7:0];
  wire [15:0] rd_low   = tb_r ? {8'h00, lo_byte} : flash_rd_data_i[15:0];
  wire [15:0] rd_high  = (tb_r && odd_r) ? 16'h0000 : {8'h00, flash_rd_data_i[23:16]};
  wire [15:0] rd_fmt   = th_r ? rd_high : rd_low;

  // register read mux; unlock register reads zero
  wire [15:0] con_val = {start_r, modify_r, abort_flag_r, 6'b000000, op_r};
  wire [15:0] rd_mux  = (reg_addr_i == flash_selfprog_pkg::OFF_CONTROL)   ? con_val :
                        (reg_addr_i == flash_selfprog_pkg::OFF_ADDR_LOW)  ? adr_lo_r :
                        (reg_addr_i == flash_selfprog_pkg::OFF_ADDR_HIGH) ? {8'h00, adr_hi_r} :
                        16'h0000;

  // next flash address: table access, program stream or erase row
  wire [23:0] faddr_nxt = take ? tbl_full_addr :
                          lat_re ? pgm_addr :
                          (start_ok && is_erase) ? row_base : flash_addr_o;

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence
  always_comb begin
    key_st_nxt = key_st_r;
    if (abort) begin
      key_st_nxt = KEY_IDLE;
    end else if (wr_key) begin
      if (reg_wdata_i[7:0] == flash_selfprog_pkg::KEY_FIRST) begin
        key_st_nxt = KEY_GOT_FIRST;
      end else if (key_st_r == KEY_GOT_FIRST && reg_wdata_i[7:0] == flash_selfprog_pkg::KEY_SECOND) begin
        key_st_nxt = KEY_ARMED;
      end else begin
        key_st_nxt = KEY_IDLE;
      end
    end else if (reg_wr_i) begin
      key_st_nxt = KEY_IDLE;
    end
  end

  // operation sequencer
  always_comb begin
    seq_nxt = seq_r;
    unique case (seq_r)
      SEQ_IDLE: begin
        if (start_ok) begin
          seq_nxt = is_erase ? SEQ_WAIT : SEQ_LOAD;
        end
      end
      SEQ_LOAD: begin
        if (abort) begin
          seq_nxt = SEQ_IDLE;
        end else if (idx_r == IDX_LAST) begin
          seq_nxt = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (abort || op_fin) begin
          seq_nxt = SEQ_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // external reset pin synchroniser
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else if (ce_i) begin
      rst_meta_r <= ext_reset_i;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_st_r <= KEY_IDLE;
      seq_r    <= SEQ_IDLE;
    end else if (ce_i) begin
      key_st_r <= key_st_nxt;
      seq_r    <= seq_nxt;
    end
  end

  // control register bits
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_r      <= 1'b0;
      modify_r     <= 1'b0;
      abort_flag_r <= 1'b0;
      op_r         <= flash_selfprog_pkg::OP_RESET;
    end else if (ce_i) begin
      // software only sets start; finish or abort clears it
      start_r      <= start_ok || (start_r && !op_fin && !abort_op);
      modify_r     <= abort ? 1'b0 : (wr_con ? new_mod : modify_r);
      // set wins over the software clear
      abort_flag_r <= abort_op || (abort_flag_r &&
                      !(wr_con && !reg_wdata_i[flash_selfprog_pkg::CTL_ABORT_BIT]));
      if (wr_con) begin
        op_r <= new_op;
      end
    end
  end

  // address registers; untouched by abort
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      adr_lo_r <= flash_selfprog_pkg::ADDR_LOW_RESET;
      adr_hi_r <= flash_selfprog_pkg::ADDR_HIGH_RESET;
    end else if (ce_i) begin
      if (take) begin
        adr_lo_r <= tbl_eff_addr_i;
        adr_hi_r <= table_page_i;
      end else begin
        if (wr_adr_lo) begin
          adr_lo_r <= reg_wdata_i;
        end
        if (wr_adr_hi) begin
          adr_hi_r <= reg_wdata_i[7:0];
        end
      end
    end
  end

  // operation timer and latch stream index
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tmr_r    <= '0;
      idx_r    <= '0;
    end else if (ce_i) begin
      tmr_r    <= (seq_r == SEQ_WAIT) ? tmr_r + 1'b1 : '0;
      idx_r    <= lat_re ? idx_r + 1'b1 : '0;
    end
  end

  // flash port and stall
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flash_rd_en_o  <= 1'b0;
      flash_addr_o   <= '0;
      flash_erase_o  <= 1'b0;
      flash_pgm_we_o <= 1'b0;
      cpu_stall_o    <= 1'b0;
      done_flag_o    <= 1'b0;
    end else if (ce_i) begin
      flash_rd_en_o  <= take && !tbl_write_i;
      flash_addr_o   <= faddr_nxt;
      flash_erase_o  <= start_ok && is_erase;
      // same edge as latch data and address, so word and slot line up
      flash_pgm_we_o <= lat_re && !abort;
      cpu_stall_o    <= (seq_nxt != SEQ_IDLE);
      done_flag_o    <= op_fin || (done_flag_o && !done_clr_i);
    end
  end

  // table request pipeline
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p1_r        <= 1'b0;
      th_r        <= 1'b0;
      tb_r        <= 1'b0;
      tw_r        <= 1'b0;
      odd_r       <= 1'b0;
      tbl_done_o  <= 1'b0;
      tbl_rdata_o <= '0;
    end else if (ce_i) begin
      p1_r       <= take;
      th_r       <= tbl_high_i;
      tb_r       <= tbl_byte_i;
      tw_r       <= tbl_write_i;
      odd_r      <= tbl_eff_addr_i[0];
      tbl_done_o <= p1_r;
      if (p1_r && !tw_r) begin
        tbl_rdata_o <= rd_fmt;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rvalid_o <= 1'b0;
      reg_rdata_o  <= '0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      reg_rdata_o  <= rd_mux;
    end
  end

  flash_write_latch_ram u_latch (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .ce_i      (ce_i),
    .we_i      (lat_we),
    .be_i      (lat_be),
    .waddr_i   (lat_widx),
    .wdata_i   (lat_wd),
    .re_i      (lat_re),
    .raddr_i   (idx_r),
    .rdata_o   (flash_pgm_data_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_tbl_two_cycle;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    take |=> ##1 tbl_done_o;
  endproperty
  a_tbl_two_cycle: assert property (p_tbl_two_cycle) else $error("table access not done in two cycles");

  property p_addr_low_capture;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    take |=> (adr_lo_r == $past(tbl_eff_addr_i));
  endproperty
  a_addr_low_capture: assert property (p_addr_low_capture) else $error("low address not captured");

  property p_addr_high_capture;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    take |=> (adr_hi_r == $past(table_page_i));
  endproperty
  a_addr_high_capture: assert property (p_addr_high_capture) else $error("high address not captured");

  property p_tbl_addr_form;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    take && !tbl_write_i |=> flash_rd_en_o && (flash_addr_o == {$past(table_page_i), $past(tbl_eff_addr_i)});
  endproperty
  a_tbl_addr_form: assert property (p_tbl_addr_form) else $error("table address badly formed");

  property p_start_needs_key;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(start_r) |-> $past(key_st_r == KEY_ARMED) && $past(reg_wdata_i[14]);
  endproperty
  a_start_needs_key: assert property (p_start_needs_key) else $error("start without unlock or modify enable");

  property p_start_held;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    start_r && ce_i && !op_fin && !abort_op |=> start_r;
  endproperty
  a_start_held: assert property (p_start_held) else $error("start bit dropped early");

  property p_disarm;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (key_st_r == KEY_ARMED) && ce_i && reg_wr_i && !wr_key |=> (key_st_r == KEY_IDLE);
  endproperty
  a_disarm: assert property (p_disarm) else $error("unlock not disarmed");

  property p_erase_row;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    flash_erase_o |-> (flash_addr_o[5:0] == 6'h00) && cpu_stall_o && (seq_r == SEQ_WAIT);
  endproperty
  a_erase_row: assert property (p_erase_row) else $error("erase not row aligned");

  property p_prog_row;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    flash_pgm_we_o |-> (flash_addr_o[23:6] == row_base[23:6]);
  endproperty
  a_prog_row: assert property (p_prog_row) else $error("program word outside row");

  property p_done_flag;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    op_fin && ce_i |=> done_flag_o && !start_r && !cpu_stall_o;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("completion not flagged");

  property p_abort;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    abort_op && ce_i |=> abort_flag_r && (seq_r == SEQ_IDLE) && $stable(adr_lo_r) && $stable(adr_hi_r);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not handled");

endmodule

`default_nettype wire

// ---- tb/flash_array_model.sv ----
// behavioural flash array on the far side of the self-write controller
`timescale 1ns/1ns
`default_nettype none

module flash_array_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rd_en_i,
  input  wire logic [23:0] addr_i,
  input  wire logic        erase_i,
  input  wire logic        pgm_we_i,
  input  wire logic [23:0] pgm_data_i,
  output logic      [23:0] rd_data_o
);
  logic [23:0] mem [0:255];
  int          n_erase = 0;
  int          n_pgm   = 0;
  logic [23:0] er_addr = 24'h000000;

  initial for (int i = 0; i < 256; i++) mem[i] = 24'hffffff;

  // a released read bus shows the inverse, never a stale word
  assign rd_data_o = rd_en_i ? mem[addr_i[8:1]] : ~mem[addr_i[8:1]];

  always @(posedge ref_clk_i) begin
    if (erase_i) begin
      er_addr = addr_i;
      n_erase++;
      for (int i = 0; i < 32; i++) mem[{addr_i[8:6], i[4:0]}] <= 24'hffffff;
    end
    if (pgm_we_i) begin
      mem[addr_i[8:1]] <= pgm_data_i;
      n_pgm++;
    end
  end
endmodule

`default_nettype wire

// ---- tb/program_flash_self_write_ctrl_bench.sv ----
// self-checking bench for the program flash self-write controller
`timescale 1ns/1ns
`default_nettype none

module program_flash_self_write_ctrl_bench;
  localparam int          OPC = 20;
  localparam logic [15:0] CTL = flash_selfprog_pkg::OFF_CONTROL;
  localparam logic [15:0] ALO = flash_selfprog_pkg::OFF_ADDR_LOW;
  localparam logic [15:0] AHI = flash_selfprog_pkg::OFF_ADDR_HIGH;
  localparam logic [15:0] KEY = flash_selfprog_pkg::OFF_UNLOCK;
  logic        ref_clk_i = 1'b0, arst_n_i = 1'b0, wdog = 1'b0, rwr = 1'b0, rrd = 1'b0, treq = 1'b0;
  logic        twr = 1'b0, thi = 1'b0, tby = 1'b0, dclr = 1'b0, xrst = 1'b0, ce = 1'b1;
  logic [15:0] radr = 16'h0000, rwd = 16'h0000, tea = 16'h0000, twd = 16'h0000, rrdata, trdata, got;
  logic [7:0]  page = 8'h00;
  logic        rvalid, tdone, fre, fer, fwe, stall, dflag;
  logic [23:0] fadr, frd, fpd, seen_adr;
  logic [23:0] img [0:31];
  int          errors = 0, n_checks = 0, seed = 59, cyc = 0, k, n;

  program_flash_self_write_ctrl #(.OP_CYCLES(OPC)) dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .ext_reset_i(xrst), .watchdog_reset_i(wdog),
    .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_addr_i(radr), .reg_wdata_i(rwd), .reg_rdata_o(rrdata),
    .reg_rvalid_o(rvalid), .tbl_req_i(treq), .tbl_write_i(twr), .tbl_high_i(thi), .tbl_byte_i(tby),
    .tbl_eff_addr_i(tea), .tbl_wdata_i(twd), .table_page_i(page), .tbl_done_o(tdone), .tbl_rdata_o(trdata),
    .flash_rd_en_o(fre), .flash_addr_o(fadr), .flash_rd_data_i(frd), .flash_erase_o(fer),
    .flash_pgm_we_o(fwe), .flash_pgm_data_o(fpd), .cpu_stall_o(stall), .done_flag_o(dflag), .done_clr_i(dclr));

  flash_array_model fm (
    .ref_clk_i(ref_clk_i), .rd_en_i(fre), .addr_i(fadr), .erase_i(fer), .pgm_we_i(fwe),
    .pgm_data_i(fpd), .rd_data_o(frd));

  always #2 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] run_length expected below 20000 seen %0d", cyc);
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] seen);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    rwr <= 1'b1;
    radr <= a;
    rwd <= d;
  endtask

  task automatic rel();
    @(posedge ref_clk_i);
    rwr <= 1'b0;
    dclr <= 1'b0;
    wdog <= 1'b0;
    xrst <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(posedge ref_clk_i);
    rrd <= 1'b1;
    radr <= a;
    @(posedge ref_clk_i);
    rrd <= 1'b0;
    #1;
    for (k = 0; k < 3 && rvalid !== 1'b1; k++) @(posedge ref_clk_i) #1;
    chk("read_valid", 24'h000001, {23'h000000, rvalid});
    chk(what, {8'h00, exp}, {8'h00, rrdata});
  endtask

  task automatic tbl(input logic w, input logic h, input logic b, input logic [15:0] ea, input logic [15:0] d);
    @(posedge ref_clk_i);
    treq <= 1'b1;
    twr <= w;
    thi <= h;
    tby <= b;
    tea <= ea;
    twd <= d;
    @(posedge ref_clk_i);
    treq <= 1'b0;
    for (n = 1; n < 5; n++) begin
      #1;
      if (fre === 1'b1) seen_adr = fadr;
      if (tdone === 1'b1) break;
      @(posedge ref_clk_i);
    end
    chk("table_latency", 24'h000002, 24'(n));
  endtask

  // mode 0 keyed start, 1 stray write after the keys, 2 no keys at all
  task automatic go(input logic [15:0] ctl, input int mode, input int lo, input int hi);
    if (mode != 2) wr(KEY, 16'h0055);
    if (mode != 2) wr(KEY, 16'h00aa);
    if (mode == 1) wr(ALO, 16'h0080);
    wr(CTL, ctl);
    rel();
    #1;
    for (n = 0; n < 400 && stall === 1'b1; n++) @(posedge ref_clk_i) #1;
    chk("stall_cycles", 24'h000001, 24'(n >= lo && n <= hi));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) rd(CTL + 16'(2 * i), 16'h0000, "reset_value");
    got = 16'($random(seed));
    wr(ALO, got);
    wr(AHI, got);
    rel();
    rd(ALO, got, "addr_low_direct");
    rd(AHI, {8'h00, got[7:0]}, "addr_high_direct");
    go(16'hc041, 2, 0, 0);
    rd(CTL, 16'h4041, "start_without_key");
    go(16'hc041, 1, 0, 0);
    go(16'h8041, 0, 0, 0);
    for (int i = 0; i < 32; i++) begin
      img[i] = 24'($random(seed));
      tbl(1'b1, 1'b0, 1'b0, 16'h0080 + 16'(2 * i), img[i][15:0]);
      tbl(1'b1, 1'b1, 1'b0, 16'h0080 + 16'(2 * i), {8'($random(seed)), img[i][23:16]});
    end
    img[0][15:0] = 16'($random(seed));
    tbl(1'b1, 1'b0, 1'b1, 16'h0080, {8'h00, img[0][7:0]});
    tbl(1'b1, 1'b0, 1'b1, 16'h0081, {8'h00, img[0][15:8]});
    chk("latch_only_write", 24'h000000, 24'(fm.n_pgm));
    go(16'hc001, 0, OPC + 32, OPC + 40);
    chk("program_words", 24'h000020, 24'(fm.n_pgm));
    chk("done_flag_set", 24'h000001, {23'h000000, dflag});
    rd(CTL, 16'h4001, "start_self_clear");
    @(posedge ref_clk_i);
    dclr <= 1'b1;
    page <= 8'h5a;
    rel();
    #1;
    chk("done_flag_clear", 24'h000000, {23'h000000, dflag});
    for (int i = 0; i < 32; i++) begin
      tbl(1'b0, 1'b0, 1'b0, 16'h0080 + 16'(2 * i), 16'h0000);
      chk("read_low", {8'h00, img[i][15:0]}, {8'h00, trdata});
      chk("read_addr", {8'h5a, 16'h0080 + 16'(2 * i)}, seen_adr);
      tbl(1'b0, 1'b1, 1'b0, 16'h0080 + 16'(2 * i), 16'h0000);
      chk("read_high", {16'h0000, img[i][23:16]}, {8'h00, trdata});
    end
    tbl(1'b0, 1'b0, 1'b1, 16'h0083, 16'h0000);
    chk("read_byte", {16'h0000, img[1][15:8]}, {8'h00, trdata});
    rd(ALO, 16'h0083, "addr_low_capture");
    rd(AHI, 16'h005a, "addr_high_capture");
    wr(AHI, 16'h0000);
    wr(ALO, 16'h0080);
    rel();
    go(16'hc041, 0, OPC, OPC + 4);
    chk("erase_count", 24'h000001, 24'(fm.n_erase));
    chk("erase_row", 24'h000080, fm.er_addr);
    tbl(1'b0, 1'b0, 1'b0, 16'h0090, 16'h0000);
    chk("erased_word", 24'h00ffff, {8'h00, trdata});
    wr(KEY, 16'h0055);
    wr(KEY, 16'h00aa);
    wr(CTL, 16'hc001);
    rel();
    repeat (10) @(posedge ref_clk_i);
    wdog <= 1'b1;
    rel();
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("abort_stall", 24'h000000, {23'h000000, stall});
    rd(CTL, 16'h2001, "abort_flag");
    rd(ALO, 16'h0090, "abort_keeps_addr");
    // software clears the aborted flag, then an external reset cuts an erase
    wr(CTL, 16'h4041);
    rel();
    rd(CTL, 16'h4041, "abort_flag_clear");
    wr(KEY, 16'h0055);
    wr(KEY, 16'h00aa);
    wr(CTL, 16'hc041);
    rel();
    repeat (5) @(posedge ref_clk_i);
    xrst <= 1'b1;
    rel();
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk("ext_abort_stall", 24'h000000, {23'h000000, stall});
    rd(CTL, 16'h2041, "ext_abort_flag");
    // a write while the clock enable is low must not land
    @(posedge ref_clk_i);
    ce <= 1'b0;
    wr(ALO, 16'h1234);
    rel();
    ce <= 1'b1;
    rd(ALO, 16'h0090, "frozen_write");
    tally_and_finish();
  end
endmodule

`default_nettype wire
